// ===== core/dmrf_lat_pipe.sv
// Latency pipeline: remembers command marks for a programmable number
// of command clocks. Assumes adv is a one-cycle pulse per command clock.
`timescale 1ns/1ps
module dmrf_lat_pipe #(
    parameter int DEPTH = 32 // Mark stages; longest delay is DEPTH-1 command clocks
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             adv,  // One pulse per command clock edge
    input  wire logic             din,  // Command mark, taken on adv
    input  wire logic [4:0]       sel,  // Delay in whole command clocks
    output logic                  q     // Level for one command clock
);

    // -----------------------------------------------------------------
    // Storage
    // -----------------------------------------------------------------
    logic [DEPTH-1:0] shift_reg; // Mark history, bit n is n clocks old
    logic [DEPTH-1:0] shift_next;
    logic             q_next;

    // Only whole clocks are possible: one stage per command clock
    assign shift_next = adv ? {shift_reg[DEPTH-2:0], din} : shift_reg;
    assign q_next     = shift_next[sel];

    // Shift and tap register
    always_ff @(posedge clock) begin
        if (rst) begin
            shift_reg <= '0;
            q         <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            q         <= q_next;
        end
    end

endmodule : dmrf_lat_pipe

// ===== core/dmrf_pkg.sv
// Shared constants and carrier types for the mode-register feature block.
// Assumes a 40 MHz system clock that samples the command clock pin and
// the command and address pins.
package dmrf_pkg;

    // -----------------------------------------------------------------
    // Command decode values (chip select, row, column, write strobe)
    // -----------------------------------------------------------------
    localparam logic [3:0] CMD_MODE_SET = 4'h0; // All four strobes low
    localparam logic [3:0] CMD_REFRESH  = 4'h1; // Self-refresh entry with clock enable low
    localparam logic [3:0] CMD_ACTIVATE = 4'h3; // Row strobe low only
    localparam logic [3:0] CMD_WRITE    = 4'h4; // Column and write strobe low
    localparam logic [3:0] CMD_READ     = 4'h5; // Column strobe low only

    // Bank selects of the mode registers
    localparam logic [2:0] BANK_FIRST  = 3'h1; // First mode register
    localparam logic [2:0] BANK_SECOND = 3'h2; // Second mode register
    localparam logic [2:0] BANK_THIRD  = 3'h3; // Third mode register

    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int FIRST_AL_LSB   = 3;  // Posted latency code, 2 bits
    localparam int FIRST_RTT_A    = 2;  // Nominal termination bit 0
    localparam int FIRST_RTT_B    = 6;  // Nominal termination bit 1
    localparam int FIRST_RTT_C    = 9;  // Nominal termination bit 2
    localparam int FIRST_LEVEL    = 7;  // Write leveling enable
    localparam int FIRST_QOFF     = 12; // Output disable
    localparam int SECOND_PARTIAL_ARRAY_SELF_REFRESH    = 0;  // Partial array field, 3 bits
    localparam int SECOND_CWL     = 3;  // Write column latency, 3 bits
    localparam int SECOND_SRT     = 7;  // Double self-refresh rate
    localparam int SECOND_RTT_WR  = 9;  // Write termination, 2 bits
    localparam int THIRD_LOC      = 0;  // Readout location, 2 bits
    localparam int THIRD_MPR      = 2;  // Readout enable

    // -----------------------------------------------------------------
    // Reset values and timing counts
    // -----------------------------------------------------------------
    localparam logic [4:0]  CWL_BASE     = 5'h05; // Latency of code zero
    localparam logic [2:0]  BURST_CK     = 3'h4;  // Command clocks of one burst
    localparam logic [13:0] MODE_RESET   = 14'h0000;
    localparam logic [15:0] MPR_PATTERN  = 16'hffff; // Readout pattern, toggled per beat

    // -----------------------------------------------------------------
    // Carrier types
    // -----------------------------------------------------------------
    typedef struct packed {
        logic        ck;      // Command clock, true leg
        logic        cke;     // Clock enable
        logic        cs_n;    // Chip select
        logic        ras_n;   // Row strobe
        logic        cas_n;   // Column strobe
        logic        we_n;    // Write strobe
        logic        odt;     // Termination request
        logic [2:0]  ba;      // Bank bits
        logic [13:0] addr;    // Address bits
    } dmrf_pins_t;

    typedef struct packed {
        logic [1:0] posted_command_latency; // Code, not cycles
        logic [2:0] rtt_nom;                // Nominal termination
        logic       write_level;            // Write leveling mode
        logic       output_disable;         // Outputs disconnected
        logic [2:0] partial_array_self_refresh;
        logic [2:0] write_column_latency;   // Code, not cycles
        logic       self_refresh_rate_double;
        logic [1:0] rtt_wr;                 // Write termination
        logic       multipurpose_readout;   // Readout enable
        logic [1:0] readout_location;       // Readout location
    } dmrf_mode_t;

endpackage : dmrf_pkg

// ===== core/dmrf_top.sv
// Mode-register feature logic of a double data rate memory device.
// Assumes a system clock at least four times the command clock.
//
// Contract
// - Delay read/write execution by posted latency
// - Read delay is posted plus column latency
// - Write delay is posted plus write latency
// - Output disable bit disconnects data and strobes
// - Bank 2 selects second mode register
// - No write termination during write leveling
// - Write termination applies without nominal termination
// - Partial refresh loses data only in self-refresh
// - Write latency from second register bits 5:3
// - Latencies are whole clocks only
// - Write termination from second register bits 10:9
// - Rate bit doubles self-refresh rate
// - Bank 3 selects third mode register
// - Location ignored while readout disabled
// - Readout mode returns predefined pattern
`timescale 1ns/1ps
module dmrf_top #(
    parameter int DEPTH = 32 // Pipe stages; longest latency sum is DEPTH-1 command clocks
) (
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire dmrf_pkg::dmrf_pins_t pins,
    input  wire logic [4:0]           read_column_latency,
    input  wire logic [15:0]          core_read_data,
    output dmrf_pkg::dmrf_mode_t      mode,
    output logic                      int_read,
    output logic                      int_write,
    output logic [4:0]                total_read_delay,
    output logic [4:0]                total_write_delay,
    output logic                      dq_oe,
    output logic                      dqs_oe,
    output logic [15:0]               dq_out,
    output logic                      write_data_expect,
    output logic [2:0]                term_code,
    output logic                      self_refresh_active,
    output logic                      self_refresh_double,
    output logic                      array_loss_possible
);

    // --------
    // Functions
    // --------
    // Latency sum, cut to five bits on purpose
    function automatic logic [4:0] lat_sum(input logic [4:0] a, input logic [4:0] b);
        logic [5:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[4:0];
    endfunction : lat_sum

    // --------
    // Pin synchroniser
    // --------
    dmrf_pkg::dmrf_pins_t pins_s1_reg; // First stage, read by second only
    dmrf_pkg::dmrf_pins_t pins_s2_reg; // Settled pin copy
    logic                 ck_prev_reg; // Last settled clock level

    // Two flops on every pin, as they come from another domain
    always_ff @(posedge clock) begin
        if (rst) begin
            pins_s1_reg <= '0;
            pins_s2_reg <= '0;
            ck_prev_reg <= 1'b0;
        end else begin
            pins_s1_reg <= pins;
            pins_s2_reg <= pins_s1_reg;
            ck_prev_reg <= pins_s2_reg.ck;
        end
    end

    // --------
    // Command decode
    // --------
    wire        ck_rise  = pins_s2_reg.ck & ~ck_prev_reg; // Command clock edge
    wire        selected = ~pins_s2_reg.cs_n;
    wire [3:0]  cmd_code = {pins_s2_reg.cs_n, pins_s2_reg.ras_n,
                            pins_s2_reg.cas_n, pins_s2_reg.we_n};
    wire [2:0]  cmd_low  = cmd_code[2:0];
    wire        is_mrs   = ck_rise & selected & (cmd_low == dmrf_pkg::CMD_MODE_SET[2:0]);
    wire        is_read  = ck_rise & selected & (cmd_low == dmrf_pkg::CMD_READ[2:0]);
    wire        is_write = ck_rise & selected & (cmd_low == dmrf_pkg::CMD_WRITE[2:0]);
    wire        is_sref  = ck_rise & selected & ~pins_s2_reg.cke
                         & (cmd_low == dmrf_pkg::CMD_REFRESH[2:0]);
    wire        sr_exit  = ck_rise & pins_s2_reg.cke;
    wire [13:0] a        = pins_s2_reg.addr;
    wire        wr_first = is_mrs & (pins_s2_reg.ba == dmrf_pkg::BANK_FIRST);
    wire        wr_sec   = is_mrs & (pins_s2_reg.ba == dmrf_pkg::BANK_SECOND);
    wire        wr_third = is_mrs & (pins_s2_reg.ba == dmrf_pkg::BANK_THIRD);

    // --------
    // Mode registers
    // --------
    dmrf_pkg::dmrf_mode_t mode_reg;
    dmrf_pkg::dmrf_mode_t mode_next;

    // Each register only changes on a set command aimed at it
    always_comb begin
        mode_next = mode_reg;
        if (wr_first) begin
            mode_next.posted_command_latency = a[dmrf_pkg::FIRST_AL_LSB +: 2];
            mode_next.rtt_nom        = {a[dmrf_pkg::FIRST_RTT_C], a[dmrf_pkg::FIRST_RTT_B],
                                        a[dmrf_pkg::FIRST_RTT_A]};
            mode_next.write_level    = a[dmrf_pkg::FIRST_LEVEL];
            mode_next.output_disable = a[dmrf_pkg::FIRST_QOFF];
        end
        if (wr_sec) begin
            // Reserved bits are left alone; the controller keeps them zero
            mode_next.partial_array_self_refresh = a[dmrf_pkg::SECOND_PARTIAL_ARRAY_SELF_REFRESH +: 3];
            mode_next.write_column_latency       = a[dmrf_pkg::SECOND_CWL +: 3];
            mode_next.self_refresh_rate_double   = a[dmrf_pkg::SECOND_SRT];
            mode_next.rtt_wr                     = a[dmrf_pkg::SECOND_RTT_WR +: 2];
        end
        if (wr_third) begin
            mode_next.multipurpose_readout = a[dmrf_pkg::THIRD_MPR];
            mode_next.readout_location     = a[dmrf_pkg::THIRD_LOC +: 2];
        end
    end

    // Mode store
    always_ff @(posedge clock) begin
        if (rst) begin
            mode_reg <= dmrf_pkg::dmrf_mode_t'(dmrf_pkg::MODE_RESET);
        end else begin
            mode_reg <= mode_next;
        end
    end

    // --------
    // Latency arithmetic
    // --------
    logic [4:0] al_cycles;     // Posted latency in clocks
    wire  [4:0] cwl_cycles = lat_sum(dmrf_pkg::CWL_BASE,
                                     {2'b00, mode_reg.write_column_latency});

    // Code one and two trail the column latency; reserved code gives zero
    always_comb begin
        case (mode_reg.posted_command_latency)
            2'h1:    al_cycles = read_column_latency - 5'h01;
            2'h2:    al_cycles = read_column_latency - 5'h02;
            default: al_cycles = 5'h00;
        endcase
    end

    wire [4:0] rl_cycles = lat_sum(al_cycles, read_column_latency);
    wire [4:0] wl_cycles = lat_sum(al_cycles, cwl_cycles);

    // --------
    // Latency pipelines
    // --------
    logic int_read_lvl;  // Internal read, one command clock
    logic int_write_lvl; // Internal write, one command clock
    logic rd_start;      // First read data clock
    logic wr_start;      // First write data clock

    // Commands taken right after activate, released after the posted delay (u_al_rd, u_al_wr) or the full read or write latency (u_rl, u_wl)
    dmrf_lat_pipe #(.DEPTH(DEPTH)) u_al_rd (
        .clock (clock), .rst (rst), .adv (ck_rise), .din (is_read),
        .sel (al_cycles), .q (int_read_lvl));
    dmrf_lat_pipe #(.DEPTH(DEPTH)) u_al_wr (
        .clock (clock), .rst (rst), .adv (ck_rise), .din (is_write),
        .sel (al_cycles), .q (int_write_lvl));
    dmrf_lat_pipe #(.DEPTH(DEPTH)) u_rl (
        .clock (clock), .rst (rst), .adv (ck_rise), .din (is_read),
        .sel (rl_cycles), .q (rd_start));
    dmrf_lat_pipe #(.DEPTH(DEPTH)) u_wl (
        .clock (clock), .rst (rst), .adv (ck_rise), .din (is_write),
        .sel (wl_cycles), .q (wr_start));

    // --------
    // Burst windows
    // --------
    logic [2:0] rd_left_reg;  // Read clocks still to drive
    logic [2:0] wr_left_reg;  // Write clocks still to receive
    logic       beat_reg;     // Pattern phase
    logic       rd_start_d_reg;
    logic       wr_start_d_reg;
    wire        rd_begin = rd_start & ~rd_start_d_reg;
    wire        wr_begin = wr_start & ~wr_start_d_reg;
    wire        rd_busy  = rd_begin | (rd_left_reg != 3'h0);
    wire        wr_busy  = wr_begin | (wr_left_reg != 3'h0);

    // Window counters step on command clock edges
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_left_reg    <= 3'h0;
            wr_left_reg    <= 3'h0;
            beat_reg       <= 1'b0;
            rd_start_d_reg <= 1'b0;
            wr_start_d_reg <= 1'b0;
        end else begin
            rd_start_d_reg <= rd_start;
            wr_start_d_reg <= wr_start;
            if (rd_begin) begin
                rd_left_reg <= dmrf_pkg::BURST_CK;
                beat_reg    <= 1'b0;
            end else if (ck_rise && rd_left_reg != 3'h0) begin
                rd_left_reg <= rd_left_reg - 3'h1;
                beat_reg    <= ~beat_reg;
            end
            if (wr_begin) begin
                wr_left_reg <= dmrf_pkg::BURST_CK;
            end else if (ck_rise && wr_left_reg != 3'h0) begin
                wr_left_reg <= wr_left_reg - 3'h1;
            end
        end
    end

    // --------
    // Output drive and termination selection
    // --------
    // Location bits are never used; readout always drives the fixed pattern
    wire        use_pattern = mode_reg.multipurpose_readout;
    wire [15:0] pattern     = beat_reg ? ~dmrf_pkg::MPR_PATTERN : dmrf_pkg::MPR_PATTERN;
    wire [15:0] dq_sel      = use_pattern ? pattern : core_read_data;
    wire        drive_en    = rd_busy & ~mode_reg.output_disable;
    wire        wr_term_ok  = wr_busy & ~mode_reg.write_level
                            & (mode_reg.rtt_wr != 2'h0);
    // Write value wins on odt during a write even if nominal is off
    wire [2:0]  term_sel    = ~pins_s2_reg.odt ? 3'h0 :
                              wr_term_ok ? {1'b1, mode_reg.rtt_wr} :
                              mode_reg.rtt_nom;

    // --------
    // Self-refresh state
    // --------
    logic sr_reg; // In self-refresh

    // Entered on the refresh command with clock enable low, left on enable high
    always_ff @(posedge clock) begin
        if (rst) begin
            sr_reg <= 1'b0;
        end else if (is_sref) begin
            sr_reg <= 1'b1;
        end else if (sr_exit) begin
            sr_reg <= 1'b0;
        end
    end

    // --------
    // Output registers
    // --------
    // Every output comes from a flop; one system clock behind its cause
    always_ff @(posedge clock) begin
        if (rst) begin
            mode                <= dmrf_pkg::dmrf_mode_t'(dmrf_pkg::MODE_RESET);
            int_read            <= 1'b0;
            int_write           <= 1'b0;
            total_read_delay    <= 5'h00;
            total_write_delay   <= 5'h00;
            dq_oe               <= 1'b0;
            dqs_oe              <= 1'b0;
            dq_out              <= 16'h0000;
            write_data_expect   <= 1'b0;
            term_code           <= 3'h0;
            self_refresh_active <= 1'b0;
            self_refresh_double <= 1'b0;
            array_loss_possible <= 1'b0;
        end else begin
            mode                <= mode_reg;
            int_read            <= int_read_lvl;
            int_write           <= int_write_lvl;
            total_read_delay    <= rl_cycles;
            total_write_delay   <= wl_cycles;
            dq_oe               <= drive_en;
            dqs_oe              <= drive_en;
            dq_out              <= drive_en ? dq_sel : 16'h0000;
            write_data_expect   <= wr_busy;
            term_code           <= term_sel;
            self_refresh_active <= sr_reg;
            self_refresh_double <= mode_reg.self_refresh_rate_double;
            // Loss only while in self-refresh with a partial range chosen
            array_loss_possible <= sr_reg & (mode_reg.partial_array_self_refresh != 3'h0);
        end
    end

endmodule : dmrf_top

// ===== sim/dmrf_ctrl_model.sv
// Controller stand-in: free command clock, one command per request.
// Assumes req is held until taken rises.
`timescale 1ns/1ps
module dmrf_ctrl_model (
    input  wire logic [4:0]      cmd,  // Clock enable, then the four strobes
    input  wire logic [2:0]      ba,   // Bank bits
    input  wire logic [13:0]     addr, // Address bits
    input  wire logic            req,  // Command wanted
    input  wire logic            odt,  // Termination request level
    output logic                 taken, // High for the command's period
    output dmrf_pkg::dmrf_pins_t pins  // Pins toward the device
);
    logic                 ck_run; // Command clock, runs free
    dmrf_pkg::dmrf_pins_t drv;    // All pins but the clock
    assign pins = {ck_run, drv[22:0]};
    // Clock phase unrelated to the system clock
    initial begin
        ck_run = 1'b0;
        taken = 1'b0;
        drv = 24'h7c0000;
        #37;
        forever #100 ck_run = ~ck_run;
    end
    // Change on the falling edge, half a period before the device samples
    always @(negedge ck_run) begin
        drv.odt <= odt;
        if (req && !taken) begin
            {drv.cke, drv.cs_n, drv.ras_n, drv.cas_n, drv.we_n} <= cmd;
            drv.ba <= {1'b0, ba[1:0]};
            drv.addr <= addr & ((ba == 3'h3) ? 14'h0007 : (ba == 3'h2) ? 14'h06bf : 14'h3fff);
            taken <= 1'b1;
        end else begin
            // Deselected: stale lines flip so no hold is implied
            {drv.cs_n, drv.ras_n, drv.cas_n, drv.we_n} <= 4'hf;
            drv.ba <= ~drv.ba;
            drv.addr <= ~drv.addr;
            taken <= 1'b0;
        end
    end
endmodule : dmrf_ctrl_model

// ===== sim/dmrf_monitor.sv
// Checker of the mode-register feature block, bound to its top.
// Assumes the 40 MHz clock and a 200 ns command clock.
`timescale 1ns/1ps
module dmrf_monitor #(
    parameter int DEPTH = 32 // Latency depth, kept equal to the design
) (
    input wire logic                 clock,
    input wire logic                 rst,
    input wire logic [4:0]           read_column_latency,
    input wire dmrf_pkg::dmrf_mode_t mode,
    input wire logic                 int_read,
    input wire logic                 int_write,
    input wire logic [4:0]           total_read_delay,
    input wire logic [4:0]           total_write_delay,
    input wire logic                 dq_oe,
    input wire logic                 dqs_oe,
    input wire logic                 write_data_expect,
    input wire logic [2:0]           term_code,
    input wire logic                 self_refresh_active,
    input wire logic                 array_loss_possible
);
    // ----------
    // Helpers
    // ----------
    logic [4:0] al;  // Posted latency in clocks
    logic [7:0] run; // System clocks the write window has stood
    assign al = (mode.posted_command_latency == 2'h1) ? read_column_latency - 5'h1 :
                (mode.posted_command_latency == 2'h2) ? read_column_latency - 5'h2 : 5'h0;
    // Window length counter, cleared whenever the window drops
    always_ff @(posedge clock) begin
        run <= (rst || !write_data_expect) ? 8'h0 : run + 8'h1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ----------
    // Properties
    // ----------
    chk_read_sum: assert property (
        ($stable(mode) && $stable(read_column_latency))[*4] |->
        total_read_delay == 5'(al + read_column_latency)) else $error("read delay sum wrong");
    chk_write_sum: assert property (
        ($stable(mode) && $stable(read_column_latency))[*4] |-> total_write_delay ==
        5'(al + dmrf_pkg::CWL_BASE + mode.write_column_latency)) else $error("write sum wrong");
    chk_qoff_quiet: assert property (
        mode.output_disable[*2] |-> !dq_oe && !dqs_oe) else $error("outputs driven while off");
    chk_write_pulse: assert property (
        $rose(int_write) |-> int_write[*8] ##1 !int_write) else $error("write pulse length");
    chk_read_pulse: assert property (
        $rose(int_read) |-> int_read[*8] ##1 !int_read) else $error("read pulse length");
    chk_window_len: assert property (
        $fell(write_data_expect) |-> run == 8'd32) else $error("write window length");
    chk_level_nodyn: assert property (
        (mode.write_level && $stable(mode))[*3] |-> term_code == 3'h0 ||
        term_code == mode.rtt_nom) else $error("write termination in leveling");
    chk_loss_gate: assert property (
        !self_refresh_active[*2] |-> !array_loss_possible) else $error("loss outside refresh");
endmodule : dmrf_monitor

bind dmrf_top dmrf_monitor #(.DEPTH(DEPTH)) u_mon (.clock(clock), .rst(rst),
    .read_column_latency(read_column_latency), .mode(mode), .int_read(int_read),
    .int_write(int_write), .total_read_delay(total_read_delay),
    .total_write_delay(total_write_delay), .dq_oe(dq_oe), .dqs_oe(dqs_oe),
    .write_data_expect(write_data_expect), .term_code(term_code),
    .self_refresh_active(self_refresh_active), .array_loss_possible(array_loss_possible));

// ===== sim/dmrf_top_bench.sv
// Self-checking bench of the mode-register feature block.
// Assumes the controller model makes the command clock.
`timescale 1ns/1ps
module dmrf_top_bench;
    typedef struct packed {logic [2:0] ba; logic [13:0] addr; logic [4:0] cl;} dmrf_row_t;
    dmrf_row_t rows [7] = '{'{3'h1, 14'h0008, 5'h09}, '{3'h2, 14'h0289, 5'h09},
        '{3'h3, 14'h0006, 5'h0b}, '{3'h0, 14'h3fff, 5'h0b}, '{3'h1, 14'h1010, 5'h0d},
        '{3'h3, 14'h0000, 5'h0d}, '{3'h1, 14'h0084, 5'h09}};
    logic clock, rst, req, odt, taken, int_read, int_write, dq_oe, dqs_oe, wde, sr_act, sr_dbl, loss;
    logic [4:0]  cmd, rcl, lat, trd, twr; // Command, latencies
    logic [2:0]  ba, term;                // Bank, termination
    logic [13:0] addr;                    // Address
    logic [15:0] core_rd, dq_out;         // Read data
    dmrf_pkg::dmrf_pins_t pins;           // Device pins
    dmrf_pkg::dmrf_mode_t mode, exp_m;    // Stored and expected fields
    int n_mismatch, checks_done, fi, fw;  // Counts, first edges seen
    dmrf_ctrl_model ctrl (.cmd(cmd), .ba(ba), .addr(addr), .req(req), .odt(odt),
        .taken(taken), .pins(pins));
    dmrf_top #(.DEPTH(32)) dut (.clock(clock), .rst(rst), .pins(pins), .mode(mode),
        .read_column_latency(rcl), .core_read_data(core_rd), .int_read(int_read),
        .int_write(int_write), .total_read_delay(trd), .total_write_delay(twr),
        .dq_oe(dq_oe), .dqs_oe(dqs_oe), .dq_out(dq_out), .write_data_expect(wde),
        .term_code(term), .self_refresh_active(sr_act), .self_refresh_double(sr_dbl),
        .array_loss_possible(loss));
    always #12.5 clock = ~clock;
    // Hang guard, well beyond the planned run
    initial begin
        #1500000;
        n_mismatch++;
        finish_test();
    end
    task automatic check(input logic ok, input string what);
        checks_done++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("Error at %0t ns: %s", $time, what);
        end
    endtask : check
    task automatic waitc(input int n);
        repeat (n) @(posedge clock);
    endtask : waitc
    function automatic dmrf_pkg::dmrf_mode_t apply(input dmrf_pkg::dmrf_mode_t m,
            input logic [2:0] b, input logic [13:0] a);
        if (b == dmrf_pkg::BANK_FIRST)
            {m.posted_command_latency, m.rtt_nom, m.write_level, m.output_disable} =
                {a[4:3], a[9], a[6], a[2], a[7], a[12]};
        if (b == dmrf_pkg::BANK_SECOND)
            {m.partial_array_self_refresh, m.write_column_latency, m.self_refresh_rate_double,
                m.rtt_wr} = {a[2:0], a[5:3], a[7], a[10:9]};
        if (b == dmrf_pkg::BANK_THIRD)
            {m.multipurpose_readout, m.readout_location} = a[2:0];
        return m;
    endfunction : apply
    // One command, held until the model takes it
    task automatic send(input logic [4:0] c, input logic [2:0] b, input logic [13:0] a);
        for (int k = 0; k < 40 && taken !== 1'b0; k++) @(posedge clock);
        @(posedge clock);
        {cmd, ba, addr, req} <= {c, b, a, 1'b1};
        for (int k = 0; k < 40 && taken !== 1'b1; k++) @(posedge clock);
        req <= 1'b0;
    endtask : send
    task automatic mrs(input logic [2:0] b, input logic [13:0] a);
        send({1'b1, dmrf_pkg::CMD_MODE_SET}, b, a);
        exp_m = apply(exp_m, b, a);
        waitc(24);
    endtask : mrs
    // Counts command clock edges to the pulse and to the window
    task automatic probe(input logic wr, input logic [2:0] exp_t);
        {fi, fw} = '0;
        @(posedge pins.ck);
        for (int k = 1; k <= 40; k++) begin
            @(posedge pins.ck);
            if (fi == 0 && (wr ? int_write : int_read) === 1'b1) fi = k;
            if (fw == 0 && (wr ? wde : dq_oe) === 1'b1) fw = k;
            if (wr && wde === 1'b1) check(term === exp_t, "termination");
            if (!wr) check(dqs_oe === dq_oe, "strobe enable");
            if (!wr && dq_oe === 1'b1) check(exp_m.multipurpose_readout ? dq_out inside
                {16'hffff, 16'h0000} : dq_out === core_rd, "read data");
        end
    endtask : probe
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : finish_test
    initial begin
        {clock, rst, req, odt, cmd, ba, addr, rcl} = {3'b010, 1'b0, 5'h1f, 17'h0, 5'h09};
        {core_rd, exp_m, n_mismatch, checks_done} = {16'h5a3c, 19'h0, 64'h0};
        waitc(16);
        rst <= 1'b0;
        waitc(4);
        check(mode === exp_m && dq_oe === 1'b0 && int_write === 1'b0, "reset");
        foreach (rows[i]) begin
            rcl <= rows[i].cl;
            mrs(rows[i].ba, rows[i].addr);
            check(mode === exp_m, "stored fields");
            lat = al_of(exp_m.posted_command_latency, rows[i].cl);
            check(trd === 5'(lat + rows[i].cl), "read delay");
            check(twr === 5'(lat + 5'h05 + exp_m.write_column_latency), "write delay");
        end
        $display("table test done");
        odt <= 1'b1;
        send({1'b1, dmrf_pkg::CMD_ACTIVATE}, 3'h0, 14'h0);
        send({1'b1, dmrf_pkg::CMD_WRITE}, 3'h0, 14'h0);
        probe(1'b1, exp_m.rtt_nom);
        check(fi === 1 && fw === 7, "leveling write");
        mrs(3'h1, 14'h0008);
        send({1'b1, dmrf_pkg::CMD_WRITE}, 3'h0, 14'h0);
        probe(1'b1, {1'b1, exp_m.rtt_wr});
        check(fi === 9 && fw === 15, "posted write");
        for (int j = 0; j < 4; j++) begin
            if (j > 0) mrs(j == 3 ? 3'h1 : 3'h3, j == 1 ? 14'h0004 : j == 2 ? 14'h0001 : 14'h1008);
            send({1'b1, dmrf_pkg::CMD_READ}, 3'h0, 14'h0);
            probe(1'b0, 3'h0);
            check(fw === (j == 3 ? 0 : 18) && fi === 9, "read timing");
        end
        $display("transfer test done");
        for (int s = 0; s < 2; s++) begin
            mrs(3'h2, (s != 0) ? 14'h0081 : 14'h0001);
            check(loss === 1'b0, "no loss");
            send({1'b0, dmrf_pkg::CMD_REFRESH}, 3'h0, 14'h0);
            waitc(24);
            check(sr_act === 1'b1 && sr_dbl === exp_m.self_refresh_rate_double, "rate");
            check(loss === 1'b1, "partial loss");
            send(5'h1f, 3'h0, 14'h0);
            waitc(24);
            check(sr_act === 1'b0 && loss === 1'b0, "refresh exit");
        end
        $display("self-refresh test done");
        rst <= 1'b1;
        waitc(4);
        rst <= 1'b0;
        waitc(2);
        check(mode === 19'h0 && sr_act === 1'b0, "second reset");
        finish_test();
    end
    function automatic logic [4:0] al_of(input logic [1:0] c, input logic [4:0] cl);
        return (c == 2'h1) ? cl - 5'h1 : (c == 2'h2) ? cl - 5'h2 : 5'h0;
    endfunction : al_of
endmodule : dmrf_top_bench
